// >>> pkg/tbw_pkg.sv
package tbw_pkg;

   // Register byte addresses.
   localparam logic [7:0] ADDR_OPTION   = 8'h94;
   localparam logic [7:0] ADDR_INTERRUPT_FLAG_STATUS   = 8'h95;
   localparam logic [7:0] ADDR_PINCTL   = 8'hA6;
   localparam logic [7:0] ADDR_RELOAD_L = 8'hCA;
   localparam logic [7:0] ADDR_RELOAD_H = 8'hCB;
   localparam logic [7:0] ADDR_COUNT_L  = 8'hCC;
   localparam logic [7:0] ADDR_COUNT_H  = 8'hCD;
   localparam logic [7:0] ADDR_AUX      = 8'hF8;

   // Field positions.
   localparam int OPT_PERIOD_MSB = 1;
   localparam int OPT_PERIOD_LSB = 0;
   localparam int FLAG_TB_BIT    = 0;
   localparam int AUX_CLR_BIT    = 6;
   localparam int AUX_SEL_B_BIT  = 2;
   localparam int AUX_SEL_A_BIT  = 1;
   localparam int PIN_EN_B_BIT   = 4;
   localparam int PIN_EN_A_BIT   = 0;

   // Reset values and codes.
   localparam logic [7:0] RESET_BYTE      = 8'h00;
   localparam logic [7:0] FLAG_CLEAR_CODE = 8'hFE;

   // Time-base counter: last count before wrap for each period code.
   localparam int          TB_W       = 15;
   localparam logic [14:0] TB_LAST_00 = 15'h7FFF;
   localparam logic [14:0] TB_LAST_01 = 15'h3FFF;
   localparam logic [14:0] TB_LAST_10 = 15'h1FFF;
   localparam logic [14:0] TB_LAST_11 = 15'h007F;
   localparam logic [14:0] TB_ZERO    = 15'h0000;

   // Slow clock by 16, and first waveform half period of 32 overflows.
   localparam logic [3:0] PRE_LAST  = 4'hF;
   localparam logic [3:0] PRE_ZERO  = 4'h0;
   localparam logic [4:0] HALF_LAST = 5'h1F;
   localparam logic [4:0] HALF_ZERO = 5'h00;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tbw_bus_s;

   typedef struct packed {
      logic p1_0_out;
      logic p1_0_oe;
      logic p3_4_out;
      logic p3_4_oe;
   } tbw_pins_s;

   typedef struct packed {
      logic [15:0] reload;
      logic [15:0] count;
   } tbw_timer_b_s;

   typedef struct packed {
      logic [7:0]  option;
      logic        tb_flag;
      logic [7:0]  pinctl;
      logic [7:0]  reload_lo;
      logic [7:0]  reload_hi;
      logic [7:0]  count_lo;
      logic [7:0]  count_hi;
      logic [7:0]  aux;
      logic [7:0]  rdata;
      logic [2:0]  slow_sync;
      logic [2:0]  pin_a_sync;
      logic [2:0]  pin_b_sync;
      logic [14:0] tb_cnt;
      logic [3:0]  pre_cnt;
      logic [4:0]  half_cnt;
      logic        wave_a;
      logic        wave_b;
      logic        evt_a;
      logic        evt_b;
   } tbw_state_s;

endpackage

// >>> src/tbw_timebase.sv
// What this block does
// - Second timer reload value: two read/write byte registers, reset to zero.
// - Second timer count: two read/write byte registers, reset to zero.
// - Second timer event source: 0 external pin, 1 slow clock divided by 16.
// - First timer event source: 0 external pin, 1 slow clock divided by 16.
// - Time-base counter advances on slow clock edges only.
// - Period code 00/01/10/11 gives 32768/16384/8192/128 slow clock cycles.
// - Flag is set each time the time-base counter completes its period.
// - Flag clears by itself when its service routine is entered.
// - Writing FEh to the flag register clears only the time-base flag.
// - Clear bit resets the time-base counter and drops itself next cycle.
// - First waveform is first timer overflows divided by 64.
// - Second waveform is second timer overflows divided by 2.
// - Second enable drives the second waveform onto P1.0, else output off.
// - First enable drives the first waveform onto P3.4, else output off.
`timescale 1ns/1ns

module tbw_timebase
   import tbw_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire tbw_bus_s     bus,
   output logic [7:0]        rdata,
   input  wire logic         slow_clock,
   input  wire logic         ext_count_a_pin,
   input  wire logic         ext_count_b_pin,
   input  wire logic         timebase_isr_enter,
   input  wire logic         ovf_first_timer,
   input  wire logic         ovf_second_timer,
   output logic              timer_a_count_event,
   output logic              timer_b_count_event,
   output logic              timebase_interrupt_flag,
   output tbw_timer_b_s      timer_b_regs,
   output tbw_pins_s         pins
);

   tbw_state_s  st_reg;
   tbw_state_s  st_next;
   logic        slow_edge;
   logic        pre_wrap;
   logic        pin_a_fall;
   logic        pin_b_fall;
   logic [14:0] tb_last;
   logic        tb_wrap;
   logic        tb_clr;
   logic        wr_flag;

   // Only the second and third stages are read; the first stage settles metastability.
   assign slow_edge  = st_reg.slow_sync[1] & ~st_reg.slow_sync[2];
   assign pin_a_fall = ~st_reg.pin_a_sync[1] & st_reg.pin_a_sync[2];
   assign pin_b_fall = ~st_reg.pin_b_sync[1] & st_reg.pin_b_sync[2];
   assign pre_wrap   = slow_edge && (st_reg.pre_cnt == PRE_LAST);
   assign tb_clr     = st_reg.aux[AUX_CLR_BIT];
   assign tb_wrap    = slow_edge && !tb_clr && (st_reg.tb_cnt == tb_last);
   assign wr_flag    = bus.wr && (bus.addr == ADDR_INTERRUPT_FLAG_STATUS);

   always_comb begin
      unique case (st_reg.option[OPT_PERIOD_MSB:OPT_PERIOD_LSB])
         2'b00: tb_last = TB_LAST_00;
         2'b01: tb_last = TB_LAST_01;
         2'b10: tb_last = TB_LAST_10;
         2'b11: tb_last = TB_LAST_11;
      endcase
   end

   always_comb begin
      st_next = st_reg;

      st_next.slow_sync  = {st_reg.slow_sync[1:0], slow_clock};
      st_next.pin_a_sync = {st_reg.pin_a_sync[1:0], ext_count_a_pin};
      st_next.pin_b_sync = {st_reg.pin_b_sync[1:0], ext_count_b_pin};

      // The clear bit lives for exactly one cycle after the write that set it.
      st_next.aux[AUX_CLR_BIT] = 1'b0;

      if (bus.wr) begin
         unique case (bus.addr)
            ADDR_OPTION:   st_next.option    = bus.wdata;
            ADDR_PINCTL:   st_next.pinctl    = bus.wdata;
            ADDR_RELOAD_L: st_next.reload_lo = bus.wdata;
            ADDR_RELOAD_H: st_next.reload_hi = bus.wdata;
            ADDR_COUNT_L:  st_next.count_lo  = bus.wdata;
            ADDR_COUNT_H:  st_next.count_hi  = bus.wdata;
            ADDR_AUX:      st_next.aux       = bus.wdata;
            default: ;
         endcase
      end

      // Read data stand only in the cycle after the read strobe.
      st_next.rdata = RESET_BYTE;
      if (bus.rd) begin
         unique case (bus.addr)
            ADDR_OPTION:   st_next.rdata = st_reg.option;
            ADDR_INTERRUPT_FLAG_STATUS:   st_next.rdata = {7'h00, st_reg.tb_flag};
            ADDR_PINCTL:   st_next.rdata = st_reg.pinctl;
            ADDR_RELOAD_L: st_next.rdata = st_reg.reload_lo;
            ADDR_RELOAD_H: st_next.rdata = st_reg.reload_hi;
            ADDR_COUNT_L:  st_next.rdata = st_reg.count_lo;
            ADDR_COUNT_H:  st_next.rdata = st_reg.count_hi;
            ADDR_AUX:      st_next.rdata = st_reg.aux;
            default:       st_next.rdata = RESET_BYTE;
         endcase
      end

      // Slow clock divided by 16 feeds both event-count selectors.
      if (slow_edge) begin
         st_next.pre_cnt = st_reg.pre_cnt + 4'h1;
      end

      // Time-base counter; a pending clear beats a slow edge in the same cycle.
      if (tb_clr) begin
         st_next.tb_cnt = TB_ZERO;
      end else if (tb_wrap) begin
         st_next.tb_cnt = TB_ZERO;
      end else if (slow_edge) begin
         st_next.tb_cnt = st_reg.tb_cnt + 15'h0001;
      end

      // Clears first, so a wrap in the same cycle still sets the flag.
      if (timebase_isr_enter) begin
         st_next.tb_flag = 1'b0;
      end
      if (wr_flag && !bus.wdata[FLAG_TB_BIT]) begin
         st_next.tb_flag = 1'b0;
      end
      if (tb_wrap) begin
         st_next.tb_flag = 1'b1;
      end

      // Event pulses to the timer engines, one cycle each.
      st_next.evt_a = st_reg.aux[AUX_SEL_A_BIT] ? pre_wrap : pin_a_fall;
      st_next.evt_b = st_reg.aux[AUX_SEL_B_BIT] ? pre_wrap : pin_b_fall;

      // Toggling every 32 overflows gives a square wave of 64 overflows.
      if (ovf_first_timer) begin
         st_next.half_cnt = st_reg.half_cnt + 5'h01;
         if (st_reg.half_cnt == HALF_LAST) begin
            st_next.wave_a = ~st_reg.wave_a;
         end
      end
      if (ovf_second_timer) begin
         st_next.wave_b = ~st_reg.wave_b;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata                   = st_reg.rdata;
   assign timer_a_count_event     = st_reg.evt_a;
   assign timer_b_count_event     = st_reg.evt_b;
   assign timebase_interrupt_flag = st_reg.tb_flag;
   assign timer_b_regs.reload     = {st_reg.reload_hi, st_reg.reload_lo};
   assign timer_b_regs.count      = {st_reg.count_hi, st_reg.count_lo};

   // With the enable low the pad falls back to its ordinary port driver.
   assign pins.p1_0_out = st_reg.wave_b;
   assign pins.p1_0_oe  = st_reg.pinctl[PIN_EN_B_BIT];
   assign pins.p3_4_out = st_reg.wave_a;
   assign pins.p3_4_oe  = st_reg.pinctl[PIN_EN_A_BIT];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_flag_set;
      tb_wrap |=> st_reg.tb_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set on wrap");

   property p_wrap_period;
      (slow_edge && !tb_clr && st_reg.option[1:0] == 2'b11 && st_reg.tb_cnt == TB_LAST_11)
         |-> tb_wrap ##1 (st_reg.tb_cnt == TB_ZERO);
   endproperty
   a_wrap_period: assert property (p_wrap_period) else $error("short period wrong");

   property p_count_on_edge;
      !slow_edge && !tb_clr |=> $stable(st_reg.tb_cnt);
   endproperty
   a_count_on_edge: assert property (p_count_on_edge) else $error("count moved");

   property p_isr_clear;
      timebase_isr_enter && !tb_wrap |=> !st_reg.tb_flag;
   endproperty
   a_isr_clear: assert property (p_isr_clear) else $error("flag kept at isr");

   property p_sw_clear;
      (wr_flag && bus.wdata == FLAG_CLEAR_CODE && !tb_wrap) |=> !st_reg.tb_flag;
   endproperty
   a_sw_clear: assert property (p_sw_clear) else $error("flag kept on write");

   property p_clr_pulse;
      (bus.wr && bus.addr == ADDR_AUX && bus.wdata[AUX_CLR_BIT])
         |=> tb_clr ##1 (!tb_clr && st_reg.tb_cnt == TB_ZERO);
   endproperty
   a_clr_pulse: assert property (p_clr_pulse) else $error("clear bit misbehaves");

   property p_sel_b;
      st_reg.aux[AUX_SEL_B_BIT] && !(bus.wr && bus.addr == ADDR_AUX)
         |-> ##1 (timer_b_count_event == $past(pre_wrap));
   endproperty
   a_sel_b: assert property (p_sel_b) else $error("second source wrong");

   property p_sel_a;
      !st_reg.aux[AUX_SEL_A_BIT] |=> (timer_a_count_event == $past(pin_a_fall));
   endproperty
   a_sel_a: assert property (p_sel_a) else $error("first source wrong");

   property p_wave_b;
      ovf_second_timer |=> (st_reg.wave_b != $past(st_reg.wave_b));
   endproperty
   a_wave_b: assert property (p_wave_b) else $error("second wave no toggle");

   property p_wave_a;
      $changed(st_reg.wave_a) |-> ($past(ovf_first_timer) && $past(st_reg.half_cnt) == HALF_LAST);
   endproperty
   a_wave_a: assert property (p_wave_a) else $error("first wave bad toggle");

   property p_pin_b;
      (bus.wr && bus.addr == ADDR_PINCTL) |=> (pins.p1_0_oe == $past(bus.wdata[PIN_EN_B_BIT]));
   endproperty
   a_pin_b: assert property (p_pin_b) else $error("P1.0 drive wrong");

   property p_pin_a;
      (bus.wr && bus.addr == ADDR_PINCTL) |=> (pins.p3_4_oe == $past(bus.wdata[PIN_EN_A_BIT]));
   endproperty
   a_pin_a: assert property (p_pin_a) else $error("P3.4 enable wrong");

   property p_reload_wr;
      (bus.wr && bus.addr == ADDR_RELOAD_L) |=> (timer_b_regs.reload[7:0] == $past(bus.wdata));
   endproperty
   a_reload_wr: assert property (p_reload_wr) else $error("reload low not stored");

   property p_count_rd;
      (bus.rd && bus.addr == ADDR_COUNT_H) |=> (rdata == timer_b_regs.count[15:8]);
   endproperty
   a_count_rd: assert property (p_count_rd) else $error("count high read wrong");

   c_wrap:    cover property (tb_wrap);
   c_isr:     cover property (st_reg.tb_flag ##1 timebase_isr_enter ##1 !st_reg.tb_flag);
   c_wave_a:  cover property ($rose(st_reg.wave_a) && pins.p3_4_oe);
   c_evt_b:   cover property (timer_b_count_event && st_reg.aux[AUX_SEL_B_BIT]);

endmodule

// >>> bench/tbw_far_side.sv
`timescale 1ns/1ns

// Far side: slow clock source and the two external count pins.
// The slow clock stands still between bursts so that edge counts are exact.
module tbw_far_side (
   input  wire logic clk,
   input  wire logic run,
   input  wire logic pull_a,
   input  wire logic pull_b,
   output logic      slow_clock,
   output logic      pin_a,
   output logic      pin_b,
   output int        edges
);
   logic [1:0] ph = 2'h0;
   initial edges = 0;
   always @(posedge clk) begin
      if (run) begin
         ph <= ph + 2'h1;
         if (ph == 2'h1) begin
            edges <= edges + 1;
         end
      end
   end
   assign slow_clock = ph[1];
   // Count pins have pull-ups, so a released pin reads high.
   assign pin_a = ~pull_a;
   assign pin_b = ~pull_b;
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ns

module tb;
   import tbw_pkg::*;
   logic         clk = 1'b0;
   logic         rstn = 1'b0;
   tbw_bus_s     bus = '0;
   logic [7:0]   rdata;
   logic         run = 1'b0, pull_a = 1'b0, pull_b = 1'b0;
   logic         slow, pa, pb, isr = 1'b0, ovf_a = 1'b0, ovf_b = 1'b0;
   logic         ev_a, ev_b, flag;
   tbw_timer_b_s tb_regs;
   tbw_pins_s    pins;
   int           edges, n_errors = 0, checked = 0, ea = 0, eb = 0, a0, b0;
   logic [7:0]   d;
   localparam logic [7:0] RA [9] = '{8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'h94, 8'hA6, 8'hF8,
                                     8'h55, 8'h95};
   localparam logic [7:0] RW [9] = '{8'h5A, 8'hA5, 8'h3C, 8'hC3, 8'hF0, 8'hEE, 8'h81,
                                     8'h77, 8'hFF};
   localparam logic [7:0] RE [9] = '{8'h5A, 8'hA5, 8'h3C, 8'hC3, 8'hF0, 8'hEE, 8'h81,
                                     8'h00, 8'h00};

   always #25 clk = ~clk;

   tbw_timebase tbw_timebase_inst (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
      .slow_clock(slow), .ext_count_a_pin(pa), .ext_count_b_pin(pb),
      .timebase_isr_enter(isr), .ovf_first_timer(ovf_a), .ovf_second_timer(ovf_b),
      .timer_a_count_event(ev_a), .timer_b_count_event(ev_b),
      .timebase_interrupt_flag(flag), .timer_b_regs(tb_regs), .pins(pins));

   tbw_far_side tbw_far_side_inst (.clk(clk), .run(run), .pull_a(pull_a),
      .pull_b(pull_b), .slow_clock(slow), .pin_a(pa), .pin_b(pb), .edges(edges));

   always @(posedge clk) begin
      if (rstn) begin
         ea <= ea + int'(ev_a);
         eb <= eb + int'(ev_b);
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk) bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk) bus.rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Waits past the synchroniser so the last edge has reached the counter.
   task automatic slow_edges(input int n);
      int target;
      target = edges + n;
      @(posedge clk) run <= 1'b1;
      while (edges < target) @(posedge clk);
      run <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
   endtask

   task automatic pulse(input bit first, input int n);
      repeat (n) begin
         @(posedge clk) if (first) ovf_a <= 1'b1; else ovf_b <= 1'b1;
         @(posedge clk) if (first) ovf_a <= 1'b0; else ovf_b <= 1'b0;
      end
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      #3000000;
      n_errors++;
      final_report();
   end

   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      foreach (RA[i]) begin
         rd(RA[i]);
         chk(d, 8'h00);
      end
      foreach (RA[i]) begin
         wr(RA[i], RW[i]);
         rd(RA[i]);
         chk(d, RE[i]);
      end
      chk(tb_regs.reload, 16'hA55A);
      chk(tb_regs.count, 16'hC33C);
      wr(8'h94, 8'h03);
      wr(8'hF8, 8'h40);
      rd(8'hF8);
      chk(d, 8'h00);
      wr(8'h95, FLAG_CLEAR_CODE);
      slow_edges(127);
      chk(flag, 1'b0);
      slow_edges(1);
      chk(flag, 1'b1);
      rd(8'h95);
      chk(d, 8'h01);
      wr(8'h95, FLAG_CLEAR_CODE);
      #1 chk(flag, 1'b0);
      slow_edges(100);
      wr(8'hF8, 8'h40);
      slow_edges(127);
      chk(flag, 1'b0);
      slow_edges(1);
      chk(flag, 1'b1);
      @(posedge clk) isr <= 1'b1;
      @(posedge clk) isr <= 1'b0;
      @(posedge clk) #1 chk(flag, 1'b0);
      wr(8'h94, 8'h02);
      wr(8'hF8, 8'h40);
      slow_edges(8191);
      chk(flag, 1'b0);
      slow_edges(1);
      chk(flag, 1'b1);
      wr(8'hF8, 8'h00);
      a0 = ea;
      b0 = eb;
      @(posedge clk) pull_a <= 1'b1;
      repeat (8) @(posedge clk);
      pull_a <= 1'b0;
      repeat (8) @(posedge clk);
      pull_b <= 1'b1;
      repeat (8) @(posedge clk);
      pull_b <= 1'b0;
      slow_edges(32);
      chk(16'(ea - a0), 16'd1);
      chk(16'(eb - b0), 16'd1);
      wr(8'hF8, 8'h06);
      a0 = ea;
      b0 = eb;
      slow_edges(32);
      chk(16'(ea - a0), 16'd2);
      chk(16'(eb - b0), 16'd2);
      wr(8'hA6, 8'h11);
      #1 chk({pins.p1_0_oe, pins.p3_4_oe}, 2'b11);
      pulse(1'b0, 1);
      chk(pins.p1_0_out, 1'b1);
      pulse(1'b0, 1);
      chk(pins.p1_0_out, 1'b0);
      pulse(1'b1, 31);
      chk(pins.p3_4_out, 1'b0);
      pulse(1'b1, 1);
      chk(pins.p3_4_out, 1'b1);
      pulse(1'b1, 32);
      chk(pins.p3_4_out, 1'b0);
      wr(8'hA6, 8'h00);
      #1 chk({pins.p1_0_oe, pins.p3_4_oe}, 2'b00);
      final_report();
   end
endmodule
